// file: design/svdc_pkg.sv
package svdc_pkg;
   localparam logic [6:0] SVDC_SLAVE_ADDR = 7'h71;
   localparam logic [2:0] SVDC_CMD_ON = 3'h0;
   localparam logic [2:0] SVDC_CMD_SETUP = 3'h1;
   localparam logic [2:0] SVDC_CMD_READ = 3'h2;
   localparam logic [2:0] SVDC_CMD_OFF = 3'h3;
   localparam logic [4:0] SVDC_CODE_RESET = 5'h1f;
   localparam int SVDC_CODE_MSB = 7;
   localparam int SVDC_CODE_LSB = 3;
   localparam int SVDC_STATUS_BIT = 2;
   localparam int SVDC_CLK_HZ = 40_000_000;
   localparam int SVDC_PG_TIME_US = 50;
   localparam int SVDC_PG_MAX_US = 70;
   localparam int SVDC_PG_CYCLES = SVDC_PG_TIME_US * (SVDC_CLK_HZ / 1_000_000);

   typedef enum logic [2:0] {
      SVDC_IDLE,
      SVDC_ADDR,
      SVDC_CMD,
      SVDC_WDATA,
      SVDC_RDATA,
      SVDC_SKIP
   } svdc_state_type;

   typedef struct packed {
      logic cpu_en;
      logic io_en;
      logic clk_en;
   } svdc_conv_type;
endpackage

// file: design/svdc_top.sv
`timescale 1ns/1ps
// Overview of operation
// - respond only to seven-bit address 1110001
// - direction bit zero writes, one reads
// - sample on SCL rise, drive on fall
// - detect start and stop while SCL high
// - decode top three command bits only
// - codes on, off, setup, read-back
// - address mismatch: release bus, wait start
// - acknowledge matching address byte
// - ack both data bytes; store on setup
// - five upper data bits form code
// - after final ack return to idle
// - read-back sends register 0 then 1
// - read byte: code, status, two zeros
// - ignore turn-on until setup done
// - two identical commands change on state
// - bus-on set by on pair, cleared by off pair
// - registers locked while converters running
// - select input picks register for divider
// - power-good low about 50 us
// - enables float only when bus-on high
// - codes reset to all ones
// - off status is NAND, forces outputs low
// - reset idles interface, status off
// - timer fires on select toggle, status fall
// - power-good low during shutdown
module svdc_top
   import svdc_pkg::*;
#(
   parameter int PG_CYCLES = svdc_pkg::SVDC_PG_CYCLES
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // serial bus
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // converter control
   input wire logic global_regulator_on_in,
   input wire logic reg_select_in,
   output svdc_pkg::svdc_conv_type conv_oe_out,
   output logic [4:0] voltage_code_bits_out,
   output logic supply_settled_flag_oe_out,
   output logic bus_on_state_out,
   output logic converter_off_status_out
);
   import svdc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // synchronisers and edge detection
   logic [1:0] scl_sync_q, sda_sync_q, von_sync_q, sel_sync_q;
   logic scl_prev_q, sda_prev_q, sel_prev_q;
   logic scl_rise, scl_fall, start_det, stop_det, sel_toggle, von;

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         von_sync_q <= 2'h0;
         sel_sync_q <= 2'h0;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
         sel_prev_q <= 1'b0;
      end else begin
         scl_sync_q <= {scl_sync_q[0], scl_in};
         sda_sync_q <= {sda_sync_q[0], sda_in};
         von_sync_q <= {von_sync_q[0], global_regulator_on_in};
         sel_sync_q <= {sel_sync_q[0], reg_select_in};
         scl_prev_q <= scl_sync_q[1];
         sda_prev_q <= sda_sync_q[1];
         sel_prev_q <= sel_sync_q[1];
      end
   end

   assign scl_rise = scl_sync_q[1] & ~scl_prev_q;
   assign scl_fall = ~scl_sync_q[1] & scl_prev_q;
   assign start_det = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
   assign stop_det = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];
   assign sel_toggle = sel_sync_q[1] ^ sel_prev_q;
   assign von = von_sync_q[1];

   ////////////////////////////////////////////////////////////////////////////
   // serial protocol engine
   svdc_state_type state_q;
   logic [7:0] shift_q;
   logic [3:0] bit_cnt_q;
   logic in_ack_q, byte_idx_q, ack_drv_q, out_drv_q, rd_ack_seen_q, sda_nack_q;
   logic [2:0] cmd_q;
   logic [4:0] code0_q, code1_q;
   logic setup_done_q, bus_on_q, pend_valid_q, pend_on_q, off_status;
   logic byte_done, rd_ack, match_now;
   logic [7:0] rd_byte;

   assign off_status = ~(von & bus_on_q);
   assign byte_done = scl_rise & ~in_ack_q & (bit_cnt_q == 4'h7);
   assign rd_ack = scl_rise & in_ack_q & (state_q == SVDC_RDATA);

   function automatic logic [7:0] read_byte(input logic [4:0] code, input logic off);
      read_byte = {code, off, 2'b00};
   endfunction

   assign rd_byte = read_byte(byte_idx_q ? code1_q : code0_q, off_status);
   // only the seven address bits take part; the eighth is the direction
   assign match_now = shift_q[6:0] == SVDC_SLAVE_ADDR;

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         state_q <= SVDC_IDLE;
         shift_q <= 8'h00;
         bit_cnt_q <= 4'h0;
         in_ack_q <= 1'b0;
         byte_idx_q <= 1'b0;
      end else if (stop_det) begin
         state_q <= SVDC_IDLE;
      end else if (start_det) begin
         state_q <= SVDC_ADDR;
         bit_cnt_q <= 4'h0;
         in_ack_q <= 1'b0;
         byte_idx_q <= 1'b0;
      end else if (state_q != SVDC_IDLE && state_q != SVDC_SKIP) begin
         if (scl_rise && !in_ack_q && state_q != SVDC_RDATA) begin
            shift_q <= {shift_q[6:0], sda_sync_q[1]};
         end
         if (byte_done) begin
            bit_cnt_q <= 4'h0;
            in_ack_q <= 1'b1;
            case (state_q)
               SVDC_ADDR: begin
                  if (!match_now) begin
                     state_q <= SVDC_SKIP;
                  end
               end
               default: begin
               end
            endcase
         end else if (scl_rise && !in_ack_q) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
         end else if (scl_fall && in_ack_q && (ack_drv_q || rd_ack_seen_q)) begin
            in_ack_q <= 1'b0;
            case (state_q)
               SVDC_ADDR: begin
                  byte_idx_q <= 1'b0;
                  state_q <= shift_q[0] ? SVDC_RDATA : SVDC_CMD;
               end
               SVDC_CMD: begin
                  state_q <= (shift_q[7:5] == SVDC_CMD_READ) ? SVDC_SKIP : SVDC_WDATA;
                  if (shift_q[7:5] > SVDC_CMD_OFF) begin
                     state_q <= SVDC_SKIP;
                  end
               end
               SVDC_WDATA: begin
                  byte_idx_q <= 1'b1;
                  if (byte_idx_q) begin
                     state_q <= SVDC_IDLE;
                  end
               end
               SVDC_RDATA: begin
                  byte_idx_q <= 1'b1;
                  if (byte_idx_q || sda_nack_q) begin
                     state_q <= SVDC_IDLE;
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // the read path keeps its own host-ack sample, seen at the ack clock's rise
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         rd_ack_seen_q <= 1'b0;
         sda_nack_q <= 1'b0;
      end else if (rd_ack) begin
         rd_ack_seen_q <= 1'b1;
         sda_nack_q <= sda_sync_q[1];
      end else if (scl_fall) begin
         rd_ack_seen_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command latch and acknowledge drive
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         cmd_q <= SVDC_CMD_READ;
      end else if (byte_done && state_q == SVDC_CMD) begin
         cmd_q <= shift_q[6:4];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in || start_det || stop_det) begin
         ack_drv_q <= 1'b0;
         out_drv_q <= 1'b0;
      end else if (scl_fall) begin
         ack_drv_q <= 1'b0;
         out_drv_q <= 1'b0;
         if (in_ack_q && !ack_drv_q && state_q != SVDC_RDATA && state_q != SVDC_SKIP &&
             state_q != SVDC_IDLE) begin
            ack_drv_q <= 1'b1;
         end
         if (state_q == SVDC_RDATA && !in_ack_q) begin
            out_drv_q <= ~rd_byte[3'(4'h7 - bit_cnt_q)];
         end
         // the first bit of each read byte goes out at the fall that ends the ack before it
         if (in_ack_q && state_q == SVDC_ADDR && ack_drv_q && shift_q[0]) begin
            out_drv_q <= ~code0_q[4];
         end
         if (in_ack_q && state_q == SVDC_RDATA && rd_ack_seen_q && !sda_nack_q && !byte_idx_q) begin
            out_drv_q <= ~code1_q[4];
         end
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe_out = ack_drv_q | out_drv_q;

   ////////////////////////////////////////////////////////////////////////////
   // registers and on/off pairing
   logic wr_byte;
   assign wr_byte = byte_done && state_q == SVDC_WDATA;

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         code0_q <= SVDC_CODE_RESET;
         code1_q <= SVDC_CODE_RESET;
         setup_done_q <= 1'b0;
      end else if (wr_byte && cmd_q == SVDC_CMD_SETUP && !(bus_on_q && von)) begin
         setup_done_q <= setup_done_q | byte_idx_q;
         if (byte_idx_q) begin
            code1_q <= shift_q[6:2];
         end else begin
            code0_q <= shift_q[6:2];
         end
      end
   end

   logic cmd_done;
   assign cmd_done = wr_byte && byte_idx_q;

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         bus_on_q <= 1'b0;
         pend_valid_q <= 1'b0;
         pend_on_q <= 1'b0;
      end else if (cmd_done || (state_q == SVDC_CMD && byte_done)) begin
         if (cmd_done && (cmd_q == SVDC_CMD_ON || cmd_q == SVDC_CMD_OFF) &&
             !(cmd_q == SVDC_CMD_ON && !setup_done_q)) begin
            pend_valid_q <= 1'b1;
            pend_on_q <= (cmd_q == SVDC_CMD_ON);
            if (pend_valid_q && pend_on_q == (cmd_q == SVDC_CMD_ON)) begin
               bus_on_q <= (cmd_q == SVDC_CMD_ON);
               pend_valid_q <= 1'b0;
            end
         end else if (!cmd_done && shift_q[6:4] != SVDC_CMD_ON && shift_q[6:4] != SVDC_CMD_OFF) begin
            pend_valid_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // divider select, enables and power-good timer
   logic off_prev_q;
   logic [$clog2(PG_CYCLES + 1)-1:0] pg_cnt_q;

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         voltage_code_bits_out <= SVDC_CODE_RESET;
      end else begin
         voltage_code_bits_out <= sel_sync_q[1] ? code1_q : code0_q;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         off_prev_q <= 1'b1;
         pg_cnt_q <= '0;
      end else begin
         off_prev_q <= off_status;
         if (off_status) begin
            pg_cnt_q <= '0;
         end else if (sel_toggle || off_prev_q) begin
            pg_cnt_q <= ($bits(pg_cnt_q))'(PG_CYCLES);
         end else if (pg_cnt_q != '0) begin
            pg_cnt_q <= pg_cnt_q - 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         conv_oe_out <= '1;
         supply_settled_flag_oe_out <= 1'b1;
      end else begin
         conv_oe_out <= {3{off_status}};
         supply_settled_flag_oe_out <= off_status | (pg_cnt_q != '0) | sel_toggle | off_prev_q;
      end
   end

   assign bus_on_state_out = bus_on_q;
   assign converter_off_status_out = off_status;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   pg_len_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      $fell(off_status) |-> ##2 supply_settled_flag_oe_out [*8]) else $error("pg pulse short");
   off_nand_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      !off_status |=> conv_oe_out == 3'b000) else $error("enables held in run");
   enables_off_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      off_status |=> conv_oe_out == 3'b111) else $error("enables released");
   pg_shut_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      off_status |=> supply_settled_flag_oe_out) else $error("pg released in shutdown");
   lock_regs_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (bus_on_q && von) |=> $stable(code0_q) && $stable(code1_q)) else $error("locked regs changed");
   on_gate_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      !setup_done_q |=> !bus_on_q || $past(bus_on_q)) else $error("on before setup");
   sel_route_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      ##1 voltage_code_bits_out == ($past(sel_sync_q[1]) ? $past(code1_q) : $past(code0_q)))
      else $error("divider route wrong");
   sel_pulse_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      sel_toggle |=> supply_settled_flag_oe_out [*3]) else $error("sel pulse missing");
endmodule

// file: tb/svdc_smb_host.sv
`timescale 1ns/1ps
module svdc_smb_host
   import svdc_pkg::*;
(
   // clock
   input wire logic clk_in,
   // bus lines
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_oe_out
);
   // scl stands high between frames; a released sda goes to the pull-up
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end

   task automatic q();
      repeat (2) @(negedge clk_in);
   endtask

   // extra quarter lets a slave release its ack before scl rises
   task automatic start();
      sda_oe_out = 1'b0;
      q();
      q();
      scl_out = 1'b1;
      q();
      sda_oe_out = 1'b1;
      q();
      scl_out = 1'b0;
   endtask

   task automatic stop();
      q();
      sda_oe_out = 1'b1;
      q();
      q();
      scl_out = 1'b1;
      q();
      sda_oe_out = 1'b0;
      q();
      q();
   endtask

   // data set mid-low, sampled mid-way through the high phase
   task automatic bit_io(input logic b, output logic r);
      q();
      sda_oe_out = ~b;
      q();
      scl_out = 1'b1;
      q();
      r = sda_in;
      q();
      scl_out = 1'b0;
   endtask

   task automatic xb(input logic [8:0] v, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         bit_io(v[i], r[i]);
      end
   endtask

   task automatic write_word(input logic [6:0] a, input logic [7:0] c, d0, d1, output logic [3:0] ack);
      logic [8:0] r;
      logic [31:0] w;
      w = {a, 1'b0, c, d0, d1};
      start();
      for (int i = 3; i >= 0; i--) begin
         xb({w[i*8+:8], 1'b1}, r);
         ack[i] = r[0];
      end
      stop();
   endtask

   task automatic read_word(output logic [7:0] d0, d1, output logic [2:0] ack);
      logic [8:0] r;
      start();
      xb({SVDC_SLAVE_ADDR, 1'b0, 1'b1}, r);
      ack[2] = r[0];
      xb({SVDC_CMD_READ, 5'h00, 1'b1}, r);
      ack[1] = r[0];
      start();
      xb({SVDC_SLAVE_ADDR, 1'b1, 1'b1}, r);
      ack[0] = r[0];
      xb(9'h1fe, r);
      d0 = r[8:1];
      xb(9'h1ff, r);
      d1 = r[8:1];
      stop();
   endtask
endmodule

// file: tb/test_smbus_vid_divider_control.sv
`timescale 1ns/1ps
`define SVDC_CHK(got, exp) \
   begin \
      checks++; \
      if ((got) !== (exp)) begin \
         n_errors++; \
         $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end

module test_smbus_vid_divider_control;
   import svdc_pkg::*;
   localparam int PGC = 40;
   localparam logic [7:0] ON = {SVDC_CMD_ON, 5'h00};
   localparam logic [7:0] OFF = {SVDC_CMD_OFF, 5'h00};
   localparam logic [7:0] SET = {SVDC_CMD_SETUP, 5'h15};
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic global_regulator_on_in = 1'b0;
   logic reg_select_in = 1'b0;
   logic scl, host_oe, dut_oe, dut_sda, pg_oe, bus_on, off;
   svdc_conv_type conv;
   logic [4:0] code;
   logic [3:0] wa;
   logic [2:0] ra;
   logic [7:0] d0, d1;
   int n_errors = 0;
   int checks = 0;
   // open-drain bus with pull-up
   wire logic sda = ~(host_oe | dut_oe);

   initial begin
      forever #12.5 sys_clk_in = ~sys_clk_in;
   end

   svdc_top #(.PG_CYCLES(PGC)) i_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
      .sda_out(dut_sda), .sda_oe_out(dut_oe), .global_regulator_on_in(global_regulator_on_in),
      .reg_select_in(reg_select_in), .conv_oe_out(conv), .voltage_code_bits_out(code),
      .supply_settled_flag_oe_out(pg_oe), .bus_on_state_out(bus_on), .converter_off_status_out(off));

   svdc_smb_host i_host (.clk_in(sys_clk_in), .sda_in(sda), .scl_out(scl), .sda_oe_out(host_oe));

   ////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      if (n_errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] c, v0, v1, input logic [3:0] exp_ack);
      i_host.write_word(a, c, v0, v1, wa);
      `SVDC_CHK(wa, exp_ack);
   endtask

   task automatic rd(input logic [7:0] e0, e1);
      i_host.read_word(d0, d1, ra);
      `SVDC_CHK({ra, d0, d1}, {3'b000, e0, e1});
   endtask

   task automatic outs(input logic [2:0] cv, input logic p, bo, of);
      `SVDC_CHK({conv, pg_oe, bus_on, off, dut_sda}, {cv, p, bo, of, 1'b0});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #1_000_000;
      n_errors++;
      final_report();
   end

   initial begin
      cyc(5);
      rst_in = 1'b0;
      cyc(4);
      outs(3'b111, 1'b1, 1'b0, 1'b1);
      `SVDC_CHK(code, SVDC_CODE_RESET);
      rd(8'hfc, 8'hfc);
      wr(SVDC_SLAVE_ADDR, ON, 8'hff, 8'hff, 4'h0);
      wr(SVDC_SLAVE_ADDR, ON, 8'hff, 8'hff, 4'h0);
      outs(3'b111, 1'b1, 1'b0, 1'b1);
      wr(7'h70, SET, 8'h00, 8'h00, 4'hf);
      // the command byte is acked before it can be decoded; the data bytes are refused
      wr(SVDC_SLAVE_ADDR, 8'he0, 8'h00, 8'h00, 4'h3);
      wr(SVDC_SLAVE_ADDR, SET, 8'ha8, 8'h37, 4'h0);
      rd(8'hac, 8'h34);
      `SVDC_CHK(code, 5'h15);
      reg_select_in = 1'b1;
      cyc(6);
      `SVDC_CHK(code, 5'h06);
      // a setup between two turn-on commands breaks the pair
      wr(SVDC_SLAVE_ADDR, ON, 8'h00, 8'h00, 4'h0);
      wr(SVDC_SLAVE_ADDR, SET, 8'ha8, 8'h37, 4'h0);
      wr(SVDC_SLAVE_ADDR, ON, 8'h00, 8'h00, 4'h0);
      `SVDC_CHK(bus_on, 1'b0);
      wr(7'h70, ON, 8'h00, 8'h00, 4'hf);
      wr(SVDC_SLAVE_ADDR, ON, 8'h00, 8'h00, 4'h0);
      cyc(4);
      outs(3'b111, 1'b1, 1'b1, 1'b1);
      global_regulator_on_in = 1'b1;
      cyc(6);
      outs(3'b000, 1'b1, 1'b1, 1'b0);
      cyc(PGC - 12);
      `SVDC_CHK(pg_oe, 1'b1);
      cyc(20);
      `SVDC_CHK(pg_oe, 1'b0);
      wr(SVDC_SLAVE_ADDR, SET, 8'h00, 8'h00, 4'h0);
      rd(8'ha8, 8'h30);
      reg_select_in = 1'b0;
      cyc(6);
      `SVDC_CHK({code, pg_oe}, {5'h15, 1'b1});
      cyc(PGC + 10);
      `SVDC_CHK(pg_oe, 1'b0);
      global_regulator_on_in = 1'b0;
      cyc(6);
      outs(3'b111, 1'b1, 1'b1, 1'b1);
      global_regulator_on_in = 1'b1;
      cyc(6);
      outs(3'b000, 1'b1, 1'b1, 1'b0);
      wr(SVDC_SLAVE_ADDR, OFF, 8'h00, 8'h00, 4'h0);
      wr(SVDC_SLAVE_ADDR, OFF, 8'h00, 8'h00, 4'h0);
      cyc(4);
      outs(3'b111, 1'b1, 1'b0, 1'b1);
      final_report();
   end
endmodule
